/* File: design/amd_pkg.sv */
// package: constants, types and register map of the mux address decoder
package amd_pkg;

    // ------------------------------------------------------------------
    // variant and serial word
    // ------------------------------------------------------------------
    localparam int NUM_CH_DEF   = 8;
    localparam int MAX_CH       = 8;
    localparam int RESULT_BITS  = 8;
    localparam int SETTLE_CLKS  = 1;
    localparam int CONV_CLKS    = SETTLE_CLKS + RESULT_BITS;
    localparam int CNT_W        = 4;

    // address bits after the start bit for a given channel count
    function automatic int addr_bits(input int num_ch);
        return (num_ch <= 1) ? 0 : $clog2(num_ch) + 1;
    endfunction

    // held word is at least two bits so the mode and sign bits always exist
    function automatic int word_w(input int num_ch);
        return (addr_bits(num_ch) < 2) ? 2 : addr_bits(num_ch);
    endfunction

    // ------------------------------------------------------------------
    // link state machine, gray along the usual path
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        AMD_WAIT_START = 2'b00,
        AMD_ADDR       = 2'b01,
        AMD_CONV       = 2'b11,
        AMD_DONE       = 2'b10
    } amd_link_state_t;

    typedef struct packed {
        logic [MAX_CH-1:0] pos;
        logic [MAX_CH-1:0] neg;
        logic              com_neg;
        logic              single;
    } amd_sel_t;

    // ------------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------------
    localparam int          AXI_AW       = 8;
    localparam logic [7:0]  REG_CTRL     = 8'h00;
    localparam logic [7:0]  REG_STATUS   = 8'h04;
    localparam logic [7:0]  REG_WORD     = 8'h08;
    localparam logic [7:0]  REG_SEL      = 8'h0c;
    localparam logic [7:0]  REG_RESULT   = 8'h10;
    localparam logic [7:0]  REG_COUNT    = 8'h14;

    localparam int          CTRL_EN_BIT  = 0;
    localparam logic        CTRL_EN_RST  = 1'b1;
    localparam int          ST_VALID_BIT = 0;
    localparam int          ST_SGL_BIT   = 1;
    localparam int          ST_COM_BIT   = 2;
    localparam int          ST_BUSY_BIT  = 3;
    localparam int          SEL_NEG_LSB  = 8;

    localparam logic [1:0]  RESP_OKAY    = 2'b00;
    localparam logic [1:0]  RESP_SLVERR  = 2'b10;
    localparam logic [31:0] RDATA_RST    = 32'h0000_0000;
    localparam logic [15:0] COUNT_RST    = 16'h0000;
    localparam logic [7:0]  RESULT_ZERO  = 8'h00;

endpackage

/* File: design/amd_link_if.sv */
// interface: address word passing from the link clock to the system clock
`timescale 1ns/100ps
interface amd_link_if #(
    parameter int WORD_W = 4
);
    logic [WORD_W-1:0] word;
    logic              word_valid;

    modport src (output word, output word_valid);
    modport dst (input word, input word_valid);
endinterface

/* File: design/amd_addr_shift.sv */
// module: serial address capture on the link clock
`timescale 1ns/100ps
module amd_addr_shift #(
    parameter int NUM_CH = amd_pkg::NUM_CH_DEF
) (
    input  wire logic  i_link_clk,
    input  wire logic  i_cs_n,
    input  wire logic  i_serial_data_in,
    amd_link_if.src    link
);
    localparam int ABITS  = amd_pkg::addr_bits(NUM_CH);
    localparam int WORD_W = amd_pkg::word_w(NUM_CH);

    amd_pkg::amd_link_state_t         state_r;
    logic [WORD_W-1:0]                shift_r;
    logic [amd_pkg::CNT_W-1:0]        cnt_r;

    // ------------------------------------------------------------------
    // start bit, address shift and conversion window
    // ------------------------------------------------------------------
    // chip select high clears asynchronously: the link clock may be parked
    // low between frames, so no edge can be relied on to do it
    always_ff @(posedge i_link_clk or posedge i_cs_n) begin
        if (i_cs_n) begin
            state_r         <= amd_pkg::AMD_WAIT_START;
            shift_r         <= '0;
            cnt_r           <= '0;
            link.word       <= '0;
            link.word_valid <= 1'b0;
        end else begin
            unique case (state_r)
                amd_pkg::AMD_WAIT_START: begin
                    if (i_serial_data_in) begin
                        cnt_r <= '0;
                        if (ABITS == 0) begin
                            state_r         <= amd_pkg::AMD_CONV;
                            link.word_valid <= 1'b1;
                        end else begin
                            state_r <= amd_pkg::AMD_ADDR;
                        end
                    end
                end
                amd_pkg::AMD_ADDR: begin
                    shift_r <= {shift_r[WORD_W-2:0], i_serial_data_in};
                    cnt_r   <= cnt_r + 1'b1;
                    if (cnt_r == amd_pkg::CNT_W'(ABITS - 1)) begin
                        // word freezes here; later data-in bits are ignored
                        link.word       <= {shift_r[WORD_W-2:0], i_serial_data_in};
                        link.word_valid <= 1'b1;
                        cnt_r           <= '0;
                        state_r         <= amd_pkg::AMD_CONV;
                    end
                end
                amd_pkg::AMD_CONV: begin
                    cnt_r <= cnt_r + 1'b1;
                    if (cnt_r == amd_pkg::CNT_W'(amd_pkg::CONV_CLKS - 1)) begin
                        link.word_valid <= 1'b0;
                        state_r         <= amd_pkg::AMD_DONE;
                    end
                end
                amd_pkg::AMD_DONE: begin
                    // a new conversion needs chip select to go high first
                    state_r <= amd_pkg::AMD_DONE;
                end
            endcase
        end
    end

endmodule // amd_addr_shift

/* File: design/amd_top.sv */
// module: mux address decoder top with register slave and result gating
`timescale 1ns/100ps
module amd_top #(
    parameter int NUM_CH = amd_pkg::NUM_CH_DEF
) (
    input  wire logic                       i_clk,
    input  wire logic                       i_rst_b,
    // serial link
    input  wire logic                       i_link_clk,
    input  wire logic                       i_cs_n,
    input  wire logic                       i_serial_data_in,
    // converter core
    input  wire logic [amd_pkg::RESULT_BITS-1:0] i_raw_code,
    input  wire logic                       i_pos_not_above_neg,
    // mux controls and result
    output logic [amd_pkg::MAX_CH-1:0]      o_pos_sel,
    output logic [amd_pkg::MAX_CH-1:0]      o_neg_sel,
    output logic                            o_common_return_input_neg,
    output logic                            o_single_or_diff_bit,
    output logic                            o_sel_valid,
    output logic [amd_pkg::RESULT_BITS-1:0] o_result,
    // axi4-lite slave
    input  wire logic [amd_pkg::AXI_AW-1:0] s_axi_awaddr,
    input  wire logic                       s_axi_awvalid,
    output logic                            s_axi_awready,
    input  wire logic [31:0]                s_axi_wdata,
    input  wire logic [3:0]                 s_axi_wstrb,
    input  wire logic                       s_axi_wvalid,
    output logic                            s_axi_wready,
    output logic [1:0]                      s_axi_bresp,
    output logic                            s_axi_bvalid,
    input  wire logic                       s_axi_bready,
    input  wire logic [amd_pkg::AXI_AW-1:0] s_axi_araddr,
    input  wire logic                       s_axi_arvalid,
    output logic                            s_axi_arready,
    output logic [31:0]                     s_axi_rdata,
    output logic [1:0]                      s_axi_rresp,
    output logic                            s_axi_rvalid,
    input  wire logic                       s_axi_rready
);
    localparam int WORD_W = amd_pkg::word_w(NUM_CH);
    localparam int RB     = amd_pkg::RESULT_BITS;

    // ------------------------------------------------------------------
    // link side
    // ------------------------------------------------------------------
    amd_link_if #(.WORD_W(WORD_W)) link ();

    amd_addr_shift #(.NUM_CH(NUM_CH)) u_shift (
        .i_link_clk       (i_link_clk),
        .i_cs_n           (i_cs_n),
        .i_serial_data_in (i_serial_data_in),
        .link             (link.src)
    );

    // ------------------------------------------------------------------
    // decode of the address word
    // ------------------------------------------------------------------
    function automatic amd_pkg::amd_sel_t decode_word(input logic [WORD_W-1:0] w);
        amd_pkg::amd_sel_t s;
        logic [1:0]        sel;
        logic [2:0]        ch;
        s   = '0;
        sel = 2'(w) & 2'((1 << (WORD_W - 2)) - 1);
        ch  = {sel, w[WORD_W-2]};
        if (NUM_CH == 1) begin
            // one fixed pair: input 0 plus, input 1 minus
            s.pos[0] = 1'b1;
            s.neg[1] = 1'b1;
        end else if (w[WORD_W-1]) begin
            s.single  = 1'b1;
            s.pos[ch] = 1'b1;
            // narrower variants tie common to ground; the flag still names it
            s.com_neg = 1'b1;
        end else if (!w[WORD_W-2]) begin
            s.pos[{sel, 1'b0}] = 1'b1;
            s.neg[{sel, 1'b1}] = 1'b1;
        end else begin
            s.pos[{sel, 1'b1}] = 1'b1;
            s.neg[{sel, 1'b0}] = 1'b1;
        end
        return s;
    endfunction

    // ------------------------------------------------------------------
    // synchronisers
    // ------------------------------------------------------------------
    logic          valid_meta_r;
    logic          valid_sync_r;
    logic          valid_seen_r;
    logic [RB-1:0] code_meta_r;
    logic [RB-1:0] code_sync_r;
    logic          le_meta_r;
    logic          le_sync_r;

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            valid_meta_r <= 1'b0;
            valid_sync_r <= 1'b0;
            valid_seen_r <= 1'b0;
        end else begin
            valid_meta_r <= link.word_valid;
            valid_sync_r <= valid_meta_r;
            valid_seen_r <= valid_sync_r;
        end
    end

    // analog-side code is only sampled at conversion end, long after it settles
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            code_meta_r <= '0;
            code_sync_r <= '0;
            le_meta_r   <= 1'b0;
            le_sync_r   <= 1'b0;
        end else begin
            code_meta_r <= i_raw_code;
            code_sync_r <= code_meta_r;
            le_meta_r   <= i_pos_not_above_neg;
            le_sync_r   <= le_meta_r;
        end
    end

    logic word_rise;
    logic word_fall;
    assign word_rise = valid_sync_r & ~valid_seen_r;
    assign word_fall = ~valid_sync_r & valid_seen_r;

    // ------------------------------------------------------------------
    // control register
    // ------------------------------------------------------------------
    logic                        ctrl_en_r;
    logic [WORD_W-1:0]           word_r;
    logic [15:0]                 count_r;
    logic                        aw_have_r;
    logic                        w_have_r;
    logic [amd_pkg::AXI_AW-1:0]  aw_addr_r;
    logic [31:0]                 w_data_r;
    logic                        w_strb0_r;
    logic                        wr_fire;

    assign wr_fire = aw_have_r & w_have_r & ~s_axi_bvalid;

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            ctrl_en_r <= amd_pkg::CTRL_EN_RST;
        end else if (wr_fire && aw_addr_r == amd_pkg::REG_CTRL && w_strb0_r) begin
            ctrl_en_r <= w_data_r[amd_pkg::CTRL_EN_BIT];
        end
    end

    // ------------------------------------------------------------------
    // selection outputs
    // ------------------------------------------------------------------
    // word is stable while its valid is high, so sampling it on the
    // synchronised rise is a safe crossing
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            word_r                    <= '0;
            o_pos_sel                 <= '0;
            o_neg_sel                 <= '0;
            o_common_return_input_neg <= 1'b0;
            o_single_or_diff_bit      <= 1'b0;
            o_sel_valid               <= 1'b0;
        end else if (word_rise && ctrl_en_r) begin
            word_r                    <= link.word;
            o_pos_sel                 <= decode_word(link.word).pos;
            o_neg_sel                 <= decode_word(link.word).neg;
            o_common_return_input_neg <= decode_word(link.word).com_neg;
            o_single_or_diff_bit      <= decode_word(link.word).single;
            o_sel_valid               <= 1'b1;
        end else if (!valid_sync_r) begin
            // conversion over or chip select released
            o_pos_sel                 <= '0;
            o_neg_sel                 <= '0;
            o_common_return_input_neg <= 1'b0;
            o_single_or_diff_bit      <= 1'b0;
            o_sel_valid               <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // result and conversion count
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            o_result <= amd_pkg::RESULT_ZERO;
            count_r  <= amd_pkg::COUNT_RST;
        end else if (word_fall && o_sel_valid) begin
            o_result <= le_sync_r ? amd_pkg::RESULT_ZERO : code_sync_r;
            count_r  <= count_r + 16'h0001;
        end
    end

    // ------------------------------------------------------------------
    // axi4-lite write channel
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            aw_have_r     <= 1'b0;
            w_have_r      <= 1'b0;
            aw_addr_r     <= '0;
            w_data_r      <= '0;
            w_strb0_r     <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= amd_pkg::RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_addr_r     <= s_axi_awaddr;
                aw_have_r     <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_data_r     <= s_axi_wdata;
                w_strb0_r    <= s_axi_wstrb[0];
                w_have_r     <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (wr_fire) begin
                aw_have_r    <= 1'b0;
                w_have_r     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (aw_addr_r == amd_pkg::REG_CTRL) ?
                                amd_pkg::RESP_OKAY : amd_pkg::RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // axi4-lite read channel
    // ------------------------------------------------------------------
    logic [31:0] rd_mux;
    logic        rd_hit;

    always_comb begin
        rd_mux = amd_pkg::RDATA_RST;
        rd_hit = 1'b1;
        unique case (s_axi_araddr)
            amd_pkg::REG_CTRL:   rd_mux[amd_pkg::CTRL_EN_BIT] = ctrl_en_r;
            amd_pkg::REG_STATUS: begin
                rd_mux[amd_pkg::ST_VALID_BIT] = o_sel_valid;
                rd_mux[amd_pkg::ST_SGL_BIT]   = o_single_or_diff_bit;
                rd_mux[amd_pkg::ST_COM_BIT]   = o_common_return_input_neg;
                rd_mux[amd_pkg::ST_BUSY_BIT]  = valid_sync_r;
            end
            amd_pkg::REG_WORD:   rd_mux[WORD_W-1:0] = word_r;
            amd_pkg::REG_SEL: begin
                rd_mux[amd_pkg::MAX_CH-1:0] = o_pos_sel;
                rd_mux[amd_pkg::SEL_NEG_LSB +: amd_pkg::MAX_CH] = o_neg_sel;
            end
            amd_pkg::REG_RESULT: rd_mux[RB-1:0] = o_result;
            amd_pkg::REG_COUNT:  rd_mux[15:0]   = count_r;
            default:             rd_hit         = 1'b0;
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= amd_pkg::RDATA_RST;
            s_axi_rresp   <= amd_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_mux;
            s_axi_rresp   <= rd_hit ? amd_pkg::RESP_OKAY : amd_pkg::RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

endmodule // amd_top

/* File: tb/amd_checker.sv */
// checker: selection, clearing and result relations at the decoder top ports
`timescale 1ns/100ps
module amd_checker (
    input  wire logic                            i_clk,
    input  wire logic                            i_rst_b,
    input  wire logic                            i_cs_n,
    input  wire logic                            i_pos_not_above_neg,
    input  wire logic [amd_pkg::MAX_CH-1:0]      o_pos_sel,
    input  wire logic [amd_pkg::MAX_CH-1:0]      o_neg_sel,
    input  wire logic                            o_common_return_input_neg,
    input  wire logic                            o_single_or_diff_bit,
    input  wire logic                            o_sel_valid,
    input  wire logic [amd_pkg::RESULT_BITS-1:0] o_result
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    chk_one_plus: assert property (
        o_sel_valid |-> $onehot(o_pos_sel)) else $error("plus select not one-hot");
    chk_single_common: assert property (
        o_sel_valid && o_single_or_diff_bit |-> o_neg_sel == 8'h00 && o_common_return_input_neg)
        else $error("single-ended minus is not the common input");
    chk_pair_adjacent: assert property (
        o_sel_valid && !o_single_or_diff_bit |-> (o_pos_sel | o_neg_sel) inside
        {8'h03, 8'h0c, 8'h30, 8'hc0} && (o_pos_sel & o_neg_sel) == 8'h00
        && !o_common_return_input_neg) else $error("differential pair not adjacent");
    chk_sel_held: assert property (
        o_sel_valid && $past(o_sel_valid) |-> $stable(o_pos_sel) && $stable(o_neg_sel)
        && $stable(o_single_or_diff_bit)) else $error("selection changed while held");
    chk_sel_span: assert property (
        $rose(o_sel_valid) |=> o_sel_valid[*8]) else $error("selection dropped early");
    chk_cs_clears: assert property (
        i_cs_n[*4] |-> !o_sel_valid) else $error("selection kept while deselected");
    chk_rise_selected: assert property (
        $rose(o_sel_valid) |-> !$past(i_cs_n, 2)) else $error("selection rose while deselected");
    chk_result_zero: assert property (
        $changed(o_result) && $past(i_pos_not_above_neg, 3) && $past(i_pos_not_above_neg, 2)
        |-> o_result == 8'h00) else $error("result not zero for plus not above minus");
endmodule // amd_checker

bind amd_top amd_checker u_chk (.i_clk, .i_rst_b, .i_cs_n, .i_pos_not_above_neg, .o_pos_sel,
    .o_neg_sel, .o_common_return_input_neg, .o_single_or_diff_bit, .o_sel_valid, .o_result);

/* File: tb/amd_proc_model.sv */
// partner: controlling processor that frames one address word on the link
`timescale 1ns/100ps
module amd_proc_model (
    output logic o_link_clk,
    output logic o_cs_n,
    output logic o_data
);
    // a real rising edge on chip select, so the link logic clears even if
    // its process wakes after time zero and misses the first assignment
    initial begin
        o_link_clk = 1'b0;
        o_cs_n     = 1'b0;
        o_data     = 1'b0;
        #1 o_cs_n  = 1'b1;
    end

    // undriven data wanders so a stale level never passes for a sample
    always #20 if (o_cs_n) o_data = ~o_data;

    // ------------------------------------------------------------------
    // one frame: leading zeros, start bit, word msb first, then filler
    // ------------------------------------------------------------------
    task automatic frame(input logic [3:0] w, input int lead, input int nclk);
        #3.3;
        o_cs_n = 1'b0;
        #30;
        for (int i = 0; i < nclk; i++) begin
            if (i < lead) o_data = 1'b0;
            else if (i == lead) o_data = 1'b1;
            else if (i <= lead + 4) o_data = w[lead + 4 - i];
            else o_data = i[0];
            #16 o_link_clk = 1'b1;
            // high phase 32 ns, clock parks low between frames
            #32 o_link_clk = 1'b0;
            #16;
        end
        o_cs_n = 1'b1;
    endtask
endmodule // amd_proc_model

/* File: tb/tb_top.sv */
// testbench: register access and address frames against the decoder top
`timescale 1ns/100ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin err_total++; \
    $display("BAD %0t got %h expected %h", $time, g, e); end end
module tb_top;
    logic        i_clk, i_rst_b, i_pos_not_above_neg, link_clk, cs_n, sdi;
    logic [7:0]  i_raw_code, s_axi_awaddr, s_axi_araddr, o_pos_sel, o_neg_sel, o_result;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        o_com, o_sgl, o_sel_valid;
    int          err_total = 0;
    int          samples_checked = 0;

    amd_proc_model u_proc (.o_link_clk(link_clk), .o_cs_n(cs_n), .o_data(sdi));

    amd_top #(.NUM_CH(8)) DUT (.i_clk, .i_rst_b, .i_link_clk(link_clk), .i_cs_n(cs_n),
        .i_serial_data_in(sdi), .i_raw_code, .i_pos_not_above_neg, .o_pos_sel, .o_neg_sel,
        .o_common_return_input_neg(o_com), .o_single_or_diff_bit(o_sgl), .o_sel_valid,
        .o_result, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

    initial begin
        i_clk = 1'b0;
        forever #2 i_clk = ~i_clk;
    end

    // ------------------------------------------------------------------
    // bus and frame tasks
    // ------------------------------------------------------------------
    // waits for the answer as long as it takes; only the watchdog ends a hang
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge i_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge i_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        `CHK(s_axi_bresp, er)
    endtask

    task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        @(posedge i_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge i_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        `CHK(s_axi_rdata, ed)
        `CHK(s_axi_rresp, er)
    endtask

    task automatic conv(input logic [3:0] w, input int lead, input int nclk, input logic en);
        logic       seen;
        logic [7:0] gp, gn, ep, en_;
        logic       gc, gs;
        seen = 1'b0;
        ep = 8'h01 << {w[1:0], w[2]};
        en_ = w[3] ? 8'h00 : 8'h01 << {w[1:0], ~w[2]};
        @(posedge i_clk);
        i_raw_code <= {w, ~w};
        i_pos_not_above_neg <= w[1];
        fork
            u_proc.frame(w, lead, nclk);
            for (int n = 0; n < 500 && !seen; n++) begin
                @(posedge i_clk);
                if (o_sel_valid === 1'b1) begin
                    seen = 1'b1;
                    {gp, gn, gc, gs} = {o_pos_sel, o_neg_sel, o_com, o_sgl};
                end
            end
        join
        `CHK(seen, en)
        if (en) begin
            `CHK(gp, ep)
            `CHK(gn, en_)
            `CHK(gc, w[3])
            `CHK(gs, w[3])
            // a cut frame ends the conversion only after the deselect crosses over
            repeat (5) @(posedge i_clk);
            `CHK(o_result, w[1] ? 8'h00 : {w, ~w})
            `CHK(o_sel_valid, 1'b0)
        end
    endtask

    task automatic tally_and_finish;
        $display("errors %0d checks %0d", err_total, samples_checked);
        if (err_total == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------------
    initial begin
        {i_rst_b, i_pos_not_above_neg, i_raw_code} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        repeat (4) @(posedge i_clk);
        i_rst_b <= 1'b1;
        axi_rd(amd_pkg::REG_CTRL, 32'h0000_0001, amd_pkg::RESP_OKAY);
        axi_rd(8'h20, 32'h0000_0000, amd_pkg::RESP_SLVERR);
        axi_wr(amd_pkg::REG_STATUS, 32'h0000_0001, amd_pkg::RESP_SLVERR);
        for (int w = 0; w < 16; w++) conv(w[3:0], w % 3, w % 3 + 16, 1'b1);
        axi_wr(amd_pkg::REG_CTRL, 32'h0000_0000, amd_pkg::RESP_OKAY);
        conv(4'hb, 1, 17, 1'b0);
        axi_wr(amd_pkg::REG_CTRL, 32'h0000_0001, amd_pkg::RESP_OKAY);
        conv(4'h9, 0, 3, 1'b0);
        conv(4'hc, 0, 8, 1'b1);
        conv(4'h9, 0, 16, 1'b1);
        axi_rd(amd_pkg::REG_COUNT, 32'd18, amd_pkg::RESP_OKAY);
        tally_and_finish();
    end

    // about four times the expected run
    initial begin
        #100000;
        err_total++;
        tally_and_finish();
    end
endmodule // tb_top
